// ===== sim/bfc_decode_sva.sv
`timescale 1ns/100ps
module bfc_decode_chk #(
  parameter int PC_W = 21
) (
  // Clock and reset
  input wire logic            clk_i,
  input wire logic            arst_n_i,
  // Instruction issue and flags
  input wire logic            insn_valid_i,
  input wire logic [15:0]     insn_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic            carry_i,
  input wire logic            negative_i,
  input wire logic            overflow_i,
  // Decoder results
  input wire logic            busy_o,
  input wire logic            match_o,
  input wire logic [1:0]      phase_o,
  input wire logic            pc_we_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic            flush_o,
  input wire logic            flags_we_o,
  input wire logic            done_o
);
  logic [7:0]      op;
  logic            hit, go, tk;
  logic [PC_W-1:0] nxt, tgt;
  assign op = insn_i[15:8];
  assign hit = op == 8'he3 || op == 8'he7 || op == 8'he5;
  assign go = insn_valid_i && !busy_o && hit;
  assign tk = op == 8'he3 ? !carry_i : op == 8'he7 ? !negative_i : !overflow_i;
  assign nxt = pc_i + PC_W'(2);
  assign tgt = nxt + PC_W'($signed({insn_i[7:0], 1'b0}));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_quarters;
    phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3 ##1 phase_o == 2'h0;
  endsequence
  sequence s_flush;
    flush_o [*4] ##1 (done_o && !flush_o);
  endsequence
  sequence s_taken_busy;
    busy_o [*7] ##1 !busy_o;
  endsequence
  sequence s_skip_quiet;
    (busy_o && !pc_we_o && !flush_o) [*3] ##1 (!busy_o && !flush_o);
  endsequence
  AST_BUSY: assert property (go |=> busy_o [*3])
    else $error("busy dropped early");
  AST_QUARTERS: assert property (go |=> s_quarters)
    else $error("phase order");
  AST_TARGET: assert property (go && tk |-> ##4 pc_we_o && pc_o == $past(tgt, 4))
    else $error("taken target");
  AST_FLUSH: assert property (go && tk |-> ##4 s_flush)
    else $error("flush cycle");
  AST_SEQ: assert property (go && !tk |-> ##4 done_o && !pc_we_o && pc_o == $past(nxt, 4))
    else $error("not taken result");
  AST_FLAGS: assert property (!flags_we_o)
    else $error("flags written");
  AST_MATCH: assert property (match_o == (insn_valid_i && hit))
    else $error("opcode match");
  AST_PULSE: assert property (pc_we_o |=> !pc_we_o)
    else $error("pc write pulse");
  AST_TAKEN_LEN: assert property (go && tk |=> s_taken_busy)
    else $error("taken branch length");
  AST_SKIP_LEN: assert property (go && !tk |=> s_skip_quiet)
    else $error("not taken branch length");
endmodule
bind bfc_decode bfc_decode_chk #(
  .PC_W (PC_W)
) u_chk (
  .clk_i        (clk_i),
  .arst_n_i     (arst_n_i),
  .insn_valid_i (insn_valid_i),
  .insn_i       (insn_i),
  .pc_i         (pc_i),
  .carry_i      (carry_i),
  .negative_i   (negative_i),
  .overflow_i   (overflow_i),
  .busy_o       (busy_o),
  .match_o      (match_o),
  .phase_o      (phase_o),
  .pc_we_o      (pc_we_o),
  .pc_o         (pc_o),
  .flush_o      (flush_o),
  .flags_we_o   (flags_we_o),
  .done_o       (done_o)
);

// ===== sim/branch_on_flag_clear_decode_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module branch_on_flag_clear_decode_bench;
  logic        clk_i = 0, arst_n_i = 0, insn_valid_i = 0;
  logic        carry_i = 0, negative_i = 0, overflow_i = 0;
  logic [15:0] insn_i = 16'h0000;
  logic [20:0] pc_i = 21'h000000, pc_o;
  logic        busy_o, match_o, pc_we_o, flush_o, flags_we_o, done_o;
  logic [1:0]  phase_o;
  int          failures = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  bfc_decode u_dut (
    .clk_i        (clk_i),
    .arst_n_i     (arst_n_i),
    .insn_valid_i (insn_valid_i),
    .insn_i       (insn_i),
    .pc_i         (pc_i),
    .carry_i      (carry_i),
    .negative_i   (negative_i),
    .overflow_i   (overflow_i),
    .busy_o       (busy_o),
    .match_o      (match_o),
    .phase_o      (phase_o),
    .pc_we_o      (pc_we_o),
    .pc_o         (pc_o),
    .flush_o      (flush_o),
    .flags_we_o   (flags_we_o),
    .done_o       (done_o)
  );
  task automatic complete_run;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Issues one branch, follows it to done and checks length, pulses and PC.
  task automatic run(input logic [7:0] op, ofs, input logic [20:0] pc,
                     input logic [2:0] cnv, input logic tk);
    int          n, we, fl;
    logic [20:0] exp;
    exp = tk ? pc + 21'h2 + 21'($signed({ofs, 1'b0})) : pc + 21'h2;
    {carry_i, negative_i, overflow_i} = cnv;
    insn_i = {op, ofs};
    pc_i = pc;
    insn_valid_i = 1;
    #1 `CHK(match_o, 1'b1)
    @(posedge clk_i);
    #1 insn_valid_i = 0;
    n = 1;
    we = 0;
    fl = 0;
    while (!done_o && n < 12)
    begin
      we += pc_we_o;
      fl += flush_o;
      @(posedge clk_i);
      #1 n++;
    end
    `CHK(n, tk ? 8 : 4)
    `CHK(we, int'(tk))
    `CHK(fl, tk ? 4 : 0)
    `CHK(pc_o, exp)
    `CHK(flags_we_o, 1'b0)
  endtask
  task automatic t_foreign;
    insn_i = 16'he140;
    insn_valid_i = 1;
    #1 `CHK(match_o, 1'b0)
    @(posedge clk_i);
    #1 `CHK(busy_o, 1'b0)
    insn_valid_i = 0;
    @(posedge clk_i);
    #1 `CHK(busy_o, 1'b0)
  endtask
  // Flags order is carry, negative, overflow; other flags set must not matter.
  task automatic t_taken;
    run(8'he3, 8'h7f, 21'h000100, 3'b011, 1);
    run(8'he7, 8'h80, 21'h000100, 3'b101, 1);
    run(8'he5, 8'hff, 21'h000010, 3'b110, 1);
  endtask
  task automatic t_not_taken;
    run(8'he3, 8'h10, 21'h1ffffe, 3'b100, 0);
    run(8'he7, 8'h10, 21'h000200, 3'b010, 0);
    run(8'he5, 8'h10, 21'h000300, 3'b001, 0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    #1 arst_n_i = 1;
    t_foreign;
    t_taken;
    t_not_taken;
    complete_run;
  end
  initial
  begin
    #20000 failures++;
    complete_run;
  end
endmodule

// ===== src/bfc_decode.sv
// Summary of operation
// - Opcode e3 branches when carry flag is zero.
// - Opcode e7 branches when negative flag is zero.
// - Opcode e5 branches when overflow flag is zero.
// - Offset byte is signed, -128 to 127, sign-extended before use.
// - Taken target is instruction address plus 2 plus twice the offset.
// - Taken costs two cycles, second a flushing no-op; not taken costs one.
// - Quarters: decode, read offset, process, write PC only when taken.
// - Status flags never change through these branches.
`timescale 1ns/100ps

module bfc_decode #(
  parameter int PC_W = bfc_pkg::PC_WIDTH
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            arst_n_i,
  // Instruction issue
  input  wire logic            insn_valid_i,
  input  wire logic [15:0]     insn_i,
  input  wire logic [PC_W-1:0] pc_i,
  // Status flags
  input  wire logic            carry_i,
  input  wire logic            negative_i,
  input  wire logic            overflow_i,
  // Results
  output logic                 busy_o,
  output logic                 match_o,
  output logic [1:0]           phase_o,
  output logic                 pc_we_o,
  output logic [PC_W-1:0]      pc_o,
  output logic                 flush_o,
  output logic                 flags_we_o,
  output logic                 done_o
);

  // The target adder needs room for a sign-extended, doubled byte offset.
  if (PC_W < 9)
  begin : g_width_check
    $error("PC_W too narrow for a signed byte offset");
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  typedef enum logic [1:0] {
    BFC_IDLE,
    BFC_EXEC,
    BFC_NOP
  } bfc_state_t;

  function automatic logic [1:0] bfc_kind(input logic [7:0] opc);
    unique case (opc)
      bfc_pkg::OPC_CARRY_CLEAR:    bfc_kind = 2'h1;
      bfc_pkg::OPC_NEGATIVE_CLEAR: bfc_kind = 2'h2;
      bfc_pkg::OPC_OVERFLOW_CLEAR: bfc_kind = 2'h3;
      default:                     bfc_kind = 2'h0;
    endcase
  endfunction

  bfc_state_t          state_q, state_d;
  bfc_pkg::bfc_phase_t ph_q, ph_d;
  logic [1:0]          kind_q, kind_d;
  logic [7:0]          ofs_q, ofs_d;
  logic [PC_W-1:0]     addr_q, addr_d;
  logic                take_q, take_d;
  logic [PC_W-1:0]     pc_q, pc_d;
  logic                pc_we_q, pc_we_d;
  logic                flush_q, flush_d;
  logic                done_q, done_d;
  logic [PC_W-1:0]     next_pc;
  logic [PC_W-1:0]     target;
  logic                flag_sel;
  logic [7:0]          opcode;

  assign opcode = insn_i[bfc_pkg::OPC_MSB:bfc_pkg::OPC_LSB];

  bfc_target #(
    .PC_W (PC_W)
  ) u_target (
    .pc_i      (addr_q),
    .ofs_i     (ofs_q),
    .next_pc_o (next_pc),
    .target_o  (target)
  );

  // Selects the flag that the decoded opcode tests; an unknown kind never branches.
  always_comb
  begin
    unique case (kind_q)
      2'h1:    flag_sel = carry_i;
      2'h2:    flag_sel = negative_i;
      2'h3:    flag_sel = overflow_i;
      default: flag_sel = 1'b1;
    endcase
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb
  begin
    state_d = state_q;
    ph_d    = ph_q;
    kind_d  = kind_q;
    ofs_d   = ofs_q;
    addr_d  = addr_q;
    take_d  = take_q;
    pc_d    = pc_q;
    pc_we_d = 1'b0;
    flush_d = 1'b0;
    done_d  = 1'b0;
    unique case (state_q)
      BFC_IDLE:
      begin
        if (insn_valid_i && bfc_kind(opcode) != 2'h0)
        begin
          // Q1 of the instruction: decode.
          kind_d  = bfc_kind(opcode);
          addr_d  = pc_i;
          state_d = BFC_EXEC;
          ph_d    = bfc_pkg::BFC_Q2;
        end
      end
      BFC_EXEC:
      begin
        unique case (ph_q)
          bfc_pkg::BFC_Q2:
          begin
            ofs_d = insn_i[bfc_pkg::OFS_MSB:bfc_pkg::OFS_LSB];
            ph_d  = bfc_pkg::BFC_Q3;
          end
          bfc_pkg::BFC_Q3:
          begin
            take_d = ~flag_sel;
            ph_d   = bfc_pkg::BFC_Q4;
          end
          default:
          begin
            ph_d = bfc_pkg::BFC_Q1;
            if (take_q)
            begin
              pc_d    = target;
              pc_we_d = 1'b1;
              flush_d = 1'b1;
              state_d = BFC_NOP;
            end
            else
            begin
              pc_d    = next_pc;
              done_d  = 1'b1;
              state_d = BFC_IDLE;
            end
          end
        endcase
      end
      BFC_NOP:
      begin
        // Second cycle: the flush stands over exactly its four quarters.
        if (ph_q == bfc_pkg::BFC_Q4)
        begin
          done_d  = 1'b1;
          state_d = BFC_IDLE;
          ph_d    = bfc_pkg::BFC_Q1;
        end
        else
        begin
          flush_d = 1'b1;
          ph_d    = bfc_pkg::bfc_phase_t'(ph_q + 2'h1);
        end
      end
      default:
      begin
        // An unused state code returns the sequencer to idle.
        state_d = BFC_IDLE;
        ph_d    = bfc_pkg::BFC_Q1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= BFC_IDLE;
      ph_q    <= bfc_pkg::BFC_Q1;
      kind_q  <= 2'h0;
      ofs_q   <= 8'h00;
      addr_q  <= '0;
      take_q  <= 1'b0;
      pc_q    <= '0;
      pc_we_q <= 1'b0;
      flush_q <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ph_q    <= ph_d;
      kind_q  <= kind_d;
      ofs_q   <= ofs_d;
      addr_q  <= addr_d;
      take_q  <= take_d;
      pc_q    <= pc_d;
      pc_we_q <= pc_we_d;
      flush_q <= flush_d;
      done_q  <= done_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign busy_o     = (state_q != BFC_IDLE);
  assign match_o    = insn_valid_i && (bfc_kind(opcode) != 2'h0);
  assign phase_o    = ph_q;
  assign pc_we_o    = pc_we_q;
  assign pc_o       = pc_q;
  assign flush_o    = flush_q;
  assign flags_we_o = 1'b0;
  assign done_o     = done_q;

endmodule

// ===== src/bfc_pkg.sv
package bfc_pkg;

  // ==========================================================================
  // Opcodes
  // ==========================================================================
  localparam logic [7:0] OPC_CARRY_CLEAR    = 8'he3;
  localparam logic [7:0] OPC_NEGATIVE_CLEAR = 8'he7;
  localparam logic [7:0] OPC_OVERFLOW_CLEAR = 8'he5;

  // ==========================================================================
  // Field positions and sizes
  // ==========================================================================
  localparam int OPC_MSB       = 15;
  localparam int OPC_LSB       = 8;
  localparam int OFS_MSB       = 7;
  localparam int OFS_LSB       = 0;
  localparam int PC_WIDTH      = 21;
  localparam int INSN_BYTES    = 2;
  localparam int QUARTERS      = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] PHASE_RST = 2'h0;

  typedef enum logic [1:0] {
    BFC_Q1,
    BFC_Q2,
    BFC_Q3,
    BFC_Q4
  } bfc_phase_t;

endpackage

// ===== src/bfc_target.sv
`timescale 1ns/100ps

module bfc_target #(
  parameter int PC_W = 21
) (
  // Inputs
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic [7:0]      ofs_i,
  // Outputs
  output logic      [PC_W-1:0] next_pc_o,
  output logic      [PC_W-1:0] target_o
);

  logic [PC_W-1:0] ofs_ext;

  if (PC_W < 9)
  begin : g_width_check
    $error("PC_W too narrow for a signed byte offset");
  end

  // The offset is two's complement from -128 to 127, widened by its sign.
  assign ofs_ext   = PC_W'({{(PC_W-8){ofs_i[7]}}, ofs_i});
  assign next_pc_o = pc_i + PC_W'(bfc_pkg::INSN_BYTES);
  assign target_o  = next_pc_o + PC_W'({ofs_ext, 1'b0});

endmodule
